/* File: core/ccp_console_panel.v */
// Overview of operation
// RL1: a switch read returns switch bits 8-15 as byte zero and bits 0-7 as byte one.
// RL2: display bytes 0..3 load second word high, second low, first high, first low.
// RL3: two sequencing modes exist and normal mode always targets byte zero.
// RL4: incremental mode steps to the next byte on each data read or write.
// RL5: a status query returns the mode selector and register-select positions.
// RL6: a variable-rate session starts halted with the address loaded by address entry.
// RL7: execute in variable-rate position starts execution showing the chosen pair.
// RL8: in single-step setting each execute press runs one instruction and refreshes.
// RL9: register-select changes during variable-rate runs retarget the display live.
// RL10: moving from single-step to a continuous rate does not halt the processor.
// RL11: both display words are 16 bits, live in variable/memory modes, static in run.
// RL12: incremental index wraps after byte 3 on writes, byte 1 on reads, zeroed on mode select.
//
// port usage notes:
// - every strobe is a one-cycle pulse, one request per cycle, back to back allowed
// - a command strobe wins over read/write index stepping in the same cycle
// - sense wins over read when both strobes arrive together
// - read and sense answers appear one cycle after the strobe with a valid pulse
// - read data holds its value until the next read or sense answer
// - execute is a level; only its rising edge counts as a press
// - holding execute high through reset gives one press once reset drops
// - a variable-rate session starts on the first press in that position,
//   single-step or not, so a later move to a continuous rate keeps stepping
// - leaving the variable-rate position ends the session without a press
// - program writes to the display words override the live update
// - live update waits for the processor's retire pulse, not for the step pulse
// - the knob maps linearly; integer rounding makes settings between the two ends slightly slow, both ends exact
//
`timescale 1ns/1ps
`include "ccp_consts.vh"
module ccp_console_panel #(
  parameter DW = 28,
  parameter [DW-1:0] STEP_MAX_CYC = `CCP_STEP_MAX_CYC,
  parameter [DW-1:0] STEP_MIN_CYC = `CCP_STEP_MIN_CYC
) (
  input wire I_CLK,               // 250 MHz clock
  input wire I_SYS_RST,           // sync reset, high
  input wire I_CMD_STB,           // output command strobe
  input wire I_CMD_SEQ,           // sequencing mode bit
  input wire I_WR_STB,            // write data strobe
  input wire [7:0] I_WR_DATA,     // write byte
  input wire I_RD_STB,            // read data strobe
  input wire I_SENSE_STB,         // sense status strobe
  input wire [15:0] I_SWITCHES,   // data/address switches
  input wire [2:0] I_MODE_SEL,    // mode selector position
  input wire [3:0] I_REG_SEL,     // register-select position
  input wire I_SINGLE_STEP,       // speed at single-step setting
  input wire [9:0] I_SPEED,       // speed knob, 0 slow
  input wire I_EXECUTE,           // execute press level
  input wire [31:0] I_SEL_PAIR,   // selected register pair value
  input wire I_INSTR_DONE,        // processor finished an instruction
  output reg [7:0] O_RD_DATA,     // read/status byte
  output reg O_RD_VALID,          // read byte valid pulse
  output reg [15:0] O_FIRST_DISP, // first display word
  output reg [15:0] O_SECOND_DISP,// second display word
  output reg O_RUN,               // processor run enable
  output reg O_STEP,              // execute one instruction pulse
  output reg O_LOAD_ADDR,         // load address into status word pulse
  output reg [15:0] O_LOAD_VAL    // address to load
);
  localparam ST_HALT = 2'h0;
  localparam ST_FULL = 2'h1;
  localparam ST_VAR = 2'h2;

  reg seq_reg;
  reg [1:0] wr_idx_reg;
  reg [1:0] rd_idx_reg;
  reg [1:0] st_reg;
  reg [1:0] st_next;
  reg exec_d_reg;
  wire exec_press = I_EXECUTE && !exec_d_reg;
  wire tick;
  wire variable_rate_position = (I_MODE_SEL == `CCP_MODE_VAR_RATE);

  // divider period pieces, product kept wide before the divide
  reg [DW+9:0] span_prod;
  reg [DW+9:0] span_step;
  reg [DW-1:0] div_val;

  // next byte index with wrap
  function [1:0] ccp_next_idx;
    input [1:0] idx;
    input [1:0] last;
    begin
      ccp_next_idx = (idx == last) ? `CCP_BYTE0 : idx + 2'h1;
    end
  endfunction

  // speed knob maps linearly between slowest and fastest period
  // multiply first so short periods in small builds still follow the knob
  always @* begin
    span_prod = {10'h000, STEP_MAX_CYC - STEP_MIN_CYC} * {{DW{1'b0}}, I_SPEED};
    span_step = span_prod / {{DW{1'b0}}, 10'h3FF};
    div_val = STEP_MAX_CYC - span_step[DW-1:0];
  end

  ccp_rate_div #(.W(DW)) u_div (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_run((st_reg == ST_VAR) && !I_SINGLE_STEP),
    .i_div(div_val),
    .o_tick(tick)
  );

  // sequencing mode and byte indices
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      seq_reg <= `CCP_SEQ_NORMAL;
      wr_idx_reg <= `CCP_BYTE0;
      rd_idx_reg <= `CCP_BYTE0;
    end else if (I_CMD_STB) begin
      seq_reg <= I_CMD_SEQ;
      wr_idx_reg <= `CCP_BYTE0; // [RL12]
      rd_idx_reg <= `CCP_BYTE0; // [RL12]
    end else begin
      if (I_WR_STB && seq_reg == `CCP_SEQ_INCR)
        wr_idx_reg <= ccp_next_idx(wr_idx_reg, `CCP_LAST_WR_BYTE); // [RL4] [RL12]
      if (I_RD_STB && seq_reg == `CCP_SEQ_INCR)
        rd_idx_reg <= ccp_next_idx(rd_idx_reg, `CCP_LAST_RD_BYTE); // [RL4] [RL12]
    end
  end

  // read and status answers
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_RD_DATA <= 8'h00;
      O_RD_VALID <= 1'b0;
    end else begin
      O_RD_VALID <= I_RD_STB || I_SENSE_STB;
      if (I_SENSE_STB)
        O_RD_DATA <= {1'b0, I_MODE_SEL, I_REG_SEL}; // [RL5]
      else if (I_RD_STB) begin
        // normal mode index stays at zero
        if (rd_idx_reg == `CCP_BYTE0) // [RL3]
          O_RD_DATA <= I_SWITCHES[15:8]; // [RL1]
        else
          O_RD_DATA <= I_SWITCHES[7:0]; // [RL1]
      end
    end
  end

  // console sequencing state
  always @* begin
    st_next = st_reg;
    case (st_reg)
      ST_HALT: begin
        if (exec_press && I_MODE_SEL == `CCP_MODE_RUN)
          st_next = ST_FULL;
        else if (exec_press && variable_rate_position)
          st_next = ST_VAR; // [RL7] [RL10]
      end
      ST_FULL: begin
        if (exec_press && I_MODE_SEL == `CCP_MODE_HALT)
          st_next = ST_HALT;
      end
      ST_VAR: begin
        if (exec_press && I_MODE_SEL == `CCP_MODE_HALT)
          st_next = ST_HALT;
        else if (!variable_rate_position)
          st_next = ST_HALT;
      end
      default: st_next = ST_HALT;
    endcase
  end

  // execution control outputs
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      st_reg <= ST_HALT;
      exec_d_reg <= 1'b0;
      O_RUN <= 1'b0;
      O_STEP <= 1'b0;
      O_LOAD_ADDR <= 1'b0;
      O_LOAD_VAL <= 16'h0000;
    end else begin
      st_reg <= st_next;
      exec_d_reg <= I_EXECUTE;
      O_RUN <= (st_next == ST_FULL);
      // address entry only while halted
      O_LOAD_ADDR <= exec_press && st_reg == ST_HALT &&
                     I_MODE_SEL == `CCP_MODE_ADDR_ENTRY; // [RL6]
      if (exec_press && st_reg == ST_HALT && I_MODE_SEL == `CCP_MODE_ADDR_ENTRY)
        O_LOAD_VAL <= I_SWITCHES; // [RL6]
      // steps: one per press single-step, per tick otherwise; speed change keeps going
      O_STEP <= (variable_rate_position && I_SINGLE_STEP && exec_press &&
                 st_reg != ST_FULL) || // [RL8]
                (st_reg == ST_VAR && tick); // [RL10]
    end
  end

  // display words: program loads, live tracking in variable and memory modes
  always @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_FIRST_DISP <= `CCP_DISP_RST;
      O_SECOND_DISP <= `CCP_DISP_RST;
    end else if (I_WR_STB) begin
      case (wr_idx_reg) // [RL2] [RL3]
        2'h0: O_SECOND_DISP[15:8] <= I_WR_DATA;
        2'h1: O_SECOND_DISP[7:0] <= I_WR_DATA;
        2'h2: O_FIRST_DISP[15:8] <= I_WR_DATA;
        default: O_FIRST_DISP[7:0] <= I_WR_DATA;
      endcase
    end else if (st_reg != ST_FULL && I_INSTR_DONE &&
                 (variable_rate_position || I_MODE_SEL == `CCP_MODE_MEMR ||
                  I_MODE_SEL == `CCP_MODE_MEMW)) begin // [RL11]
      // selection read each update so switch changes show at the next retire pulse
      if (I_REG_SEL == `CCP_SEL_OFF) begin // [RL9]
        O_FIRST_DISP <= 16'h0000;
        O_SECOND_DISP <= 16'h0000;
      end else begin
        O_FIRST_DISP <= I_SEL_PAIR[31:16]; // [RL7] [RL8]
        O_SECOND_DISP <= I_SEL_PAIR[15:0];
      end
    end
  end
endmodule // ccp_console_panel

/* File: inc/ccp_consts.vh */
`ifndef CCP_CONSTS_VH
`define CCP_CONSTS_VH
// byte sequencing modes (output command bit)
`define CCP_SEQ_NORMAL 1'b0
`define CCP_SEQ_INCR 1'b1
// byte index limits
`define CCP_LAST_WR_BYTE 2'h3
`define CCP_LAST_RD_BYTE 2'h1
`define CCP_BYTE0 2'h0
// operating mode selector codes
`define CCP_MODE_RUN 3'h0
`define CCP_MODE_HALT 3'h1
`define CCP_MODE_VAR_RATE 3'h2
`define CCP_MODE_ADDR_ENTRY 3'h3
`define CCP_MODE_MEMR 3'h4
`define CCP_MODE_MEMW 3'h5
// register-select code for blank display
`define CCP_SEL_OFF 4'hF
// variable rate limits in steps per second
`define CCP_RATE_MIN 1
`define CCP_RATE_MAX 1000
`define CCP_CLK_HZ 250000000
`define CCP_STEP_MAX_CYC (`CCP_CLK_HZ / `CCP_RATE_MIN)
`define CCP_STEP_MIN_CYC (`CCP_CLK_HZ / `CCP_RATE_MAX)
// reset values
`define CCP_DISP_RST 16'h0000
`endif

/* File: core/ccp_rate_div.v */
`timescale 1ns/1ps
`include "ccp_consts.vh"
// programmable divider giving one-cycle step enables
module ccp_rate_div #(
  parameter W = 28
) (
  input wire i_clk,         // clock
  input wire i_rst,         // sync reset
  input wire i_run,         // divider active
  input wire [W-1:0] i_div, // period in cycles
  output reg o_tick         // step pulse
);
  reg [W-1:0] cnt_reg;
  // count down, pulse on expiry, reload with current period
  always @(posedge i_clk) begin
    if (i_rst || !i_run) begin
      cnt_reg <= {W{1'b0}};
      o_tick <= 1'b0;
    end else if (cnt_reg == {W{1'b0}}) begin
      cnt_reg <= i_div - {{(W-1){1'b0}}, 1'b1};
      o_tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
      o_tick <= 1'b0;
    end
  end
endmodule // ccp_rate_div

/* File: bench/ccp_host_model.sv */
`timescale 1ns/1ps
// processor side: programmed i/o strobes, instruction retire
module ccp_host_model (
  input wire i_clk, // clock
  input wire i_step, // step request
  input wire i_slow, // retire late
  output reg [3:0] o_stb = 4'h0, // sense, read, write, command
  output reg [7:0] o_data = 8'h00, // write byte, bit 0 mode
  output reg o_done = 1'b0 // instruction retired
);
  reg [3:0] lag_reg = 4'h0;
  // retire one or four cycles after a step
  always @(posedge i_clk) begin
    lag_reg <= {lag_reg[2:0], i_step};
    o_done <= i_slow ? lag_reg[2] : i_step;
  end
  // one instruction per edge; idle inverts the bus so stale data never looks held
  task issue(input [3:0] k, input [7:0] d);
    @(posedge i_clk);
    o_stb <= k;
    o_data <= (k == 4'h0) ? ~o_data : d;
  endtask
endmodule // ccp_host_model

/* File: bench/ccp_asserts.sv */
`timescale 1ns/1ps
// port protocol checks
module ccp_asserts (
  input wire I_CLK, I_SYS_RST, I_CMD_STB, I_CMD_SEQ, I_WR_STB, I_RD_STB, I_SENSE_STB, // strobes
  input wire I_EXECUTE, I_SINGLE_STEP, O_RD_VALID, O_RUN, O_STEP, O_LOAD_ADDR, // controls
  input wire [7:0] I_WR_DATA, O_RD_DATA, // bytes
  input wire [15:0] I_SWITCHES, O_SECOND_DISP, O_LOAD_VAL, // words
  input wire [2:0] I_MODE_SEL, // selector
  input wire [3:0] I_REG_SEL // register select
);
  // lone strobes and mode commands
  wire rdo = I_RD_STB & ~I_SENSE_STB & ~I_CMD_STB & ~I_WR_STB;
  wire wro = I_WR_STB & ~I_RD_STB & ~I_SENSE_STB & ~I_CMD_STB;
  wire inc = I_CMD_STB & I_CMD_SEQ;
  wire nrm = I_CMD_STB & ~I_CMD_SEQ;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  property p_valid; O_RD_VALID == $past(I_RD_STB | I_SENSE_STB); endproperty
  a_valid: assert property (p_valid) else $error("valid");
  property p_nrd; nrm ##1 rdo [*2] |=> O_RD_DATA == $past(I_SWITCHES[15:8]); endproperty
  a_nrd: assert property (p_nrd) else $error("normal read");
  property p_ird; inc ##1 rdo [*2] |=> O_RD_DATA == $past(I_SWITCHES[7:0]); endproperty
  a_ird: assert property (p_ird) else $error("incr read");
  property p_sns; I_SENSE_STB |=> O_RD_DATA == {1'b0, $past(I_MODE_SEL), $past(I_REG_SEL)}; endproperty
  a_sns: assert property (p_sns) else $error("sense");
  property p_nwr; nrm ##1 wro [*2] |=> O_SECOND_DISP[15:8] == $past(I_WR_DATA); endproperty
  a_nwr: assert property (p_nwr) else $error("normal write");
  property p_wrap; inc ##1 wro [*5] |=> O_SECOND_DISP[15:8] == $past(I_WR_DATA); endproperty
  a_wrap: assert property (p_wrap) else $error("write wrap");
  property p_adr; $rose(I_EXECUTE) && I_MODE_SEL == 3'h3 && !O_RUN
    |=> O_LOAD_ADDR && O_LOAD_VAL == $past(I_SWITCHES); endproperty
  a_adr: assert property (p_adr) else $error("address load");
  property p_stp; $rose(I_EXECUTE) && I_MODE_SEL == 3'h2 && I_SINGLE_STEP |-> ##[1:4] O_STEP; endproperty
  a_stp: assert property (p_stp) else $error("single step");
  c_wrap: cover property (inc ##1 wro [*5]);
  c_adr: cover property (O_LOAD_ADDR);
  c_stp: cover property (O_STEP);
endmodule // ccp_asserts
bind ccp_console_panel ccp_asserts u_chk (.*);

/* File: bench/tb_console_display_panel_port.sv */
`timescale 1ns/1ps
module tb_console_display_panel_port;
  reg I_CLK = 1'b0, I_SYS_RST = 1'b1, I_SINGLE_STEP = 1'b0, I_EXECUTE = 1'b0, slow = 1'b0;
  reg [2:0] I_MODE_SEL = 3'h1;
  reg [3:0] I_REG_SEL = 4'h0;
  reg [9:0] I_SPEED = 10'h000;
  reg [15:0] I_SWITCHES = 16'h0000;
  reg [31:0] I_SEL_PAIR = 32'h00000000, lf = 32'h00012678;
  reg [7:0] q[$], b[0:3];
  wire [3:0] stb;
  wire [7:0] wd, O_RD_DATA;
  wire [15:0] O_FIRST_DISP, O_SECOND_DISP, O_LOAD_VAL;
  wire O_RD_VALID, O_RUN, O_STEP, O_LOAD_ADDR, I_INSTR_DONE;
  integer failures = 0, checks = 0, steps = 0, loads = 0, i;
  ccp_host_model host (.i_clk(I_CLK), .i_step(O_STEP), .i_slow(slow), .o_stb(stb), .o_data(wd),
    .o_done(I_INSTR_DONE));
  ccp_console_panel #(.STEP_MAX_CYC(28'h0000028), .STEP_MIN_CYC(28'h0000004)) DUT (.*,
    .I_CMD_STB(stb[0]), .I_CMD_SEQ(wd[0]), .I_WR_STB(stb[1]), .I_WR_DATA(wd), .I_RD_STB(stb[2]),
    .I_SENSE_STB(stb[3]));
  // 250 MHz clock
  always #2 I_CLK = ~I_CLK;
  function [31:0] nx(input [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task chk(input [15:0] e, input [15:0] g, input string n);
    checks = checks + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task rd(input [3:0] k, input [7:0] e);
    q.push_back(e);
    host.issue(k, 8'h00);
  endtask
  task press;
    @(posedge I_CLK) I_EXECUTE <= 1'b1;
    repeat (8) @(posedge I_CLK);
    I_EXECUTE <= 1'b0;
    repeat (8) @(posedge I_CLK);
  endtask
  // read answers against oldest note, step count
  always @(posedge I_CLK) begin
    if (O_RD_VALID === 1'b1) chk(q.pop_front(), O_RD_DATA, "rd");
    if (O_STEP === 1'b1) steps = steps + 1;
    if (O_LOAD_ADDR === 1'b1) loads = loads + 1;
  end
  // hang guard
  initial begin
    #20000;
    failures = failures + 1;
    give_verdict;
  end
  // programmed i/o, then console sessions
  initial begin
    repeat (2) @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    I_SWITCHES <= lf[15:0];
    host.issue(4'h1, 8'h00);
    rd(4'h4, lf[15:8]);
    rd(4'h4, lf[15:8]);
    host.issue(4'h1, 8'h01);
    rd(4'h4, lf[15:8]);
    rd(4'h4, lf[7:0]);
    rd(4'h4, lf[15:8]);
    for (i = 0; i < 6; i = i + 1) begin
      lf = nx(lf);
      I_MODE_SEL <= i[2:0];
      I_REG_SEL <= lf[3:0];
      rd(4'h8, {1'b0, i[2:0], lf[3:0]});
      host.issue(4'h0, 8'h00);
    end
    I_MODE_SEL <= 3'h1;
    host.issue(4'h1, 8'h01);
    for (i = 0; i < 5; i = i + 1) begin
      lf = nx(lf);
      b[i % 4] = lf[7:0];
      host.issue(4'h2, lf[7:0]);
    end
    host.issue(4'h1, 8'h00);
    host.issue(4'h2, b[0]);
    host.issue(4'h2, b[3]);
    host.issue(4'h0, 8'h00);
    @(negedge I_CLK);
    chk({b[3], b[1]}, O_SECOND_DISP, "disp2");
    chk({b[2], b[3]}, O_FIRST_DISP, "disp1");
    @(posedge I_CLK) I_MODE_SEL <= 3'h3;
    press;
    chk(16'h0001, loads[15:0], "load");
    chk(I_SWITCHES, O_LOAD_VAL, "ldval");
    I_MODE_SEL <= 3'h2;
    I_SINGLE_STEP <= 1'b1;
    I_SEL_PAIR <= lf;
    I_REG_SEL <= 4'h1;
    press;
    press;
    chk(16'h0002, steps[15:0], "steps");
    chk(lf[31:16], O_FIRST_DISP, "vd1");
    lf = nx(lf);
    I_SPEED <= lf[9:0];
    I_SEL_PAIR <= lf;
    I_REG_SEL <= 4'h2;
    I_SINGLE_STEP <= 1'b0;
    slow <= 1'b1;
    repeat (300) @(posedge I_CLK);
    chk(16'h0001, {15'h0000, steps > 5}, "rate");
    chk(lf[15:0], O_SECOND_DISP, "vd2");
    I_MODE_SEL <= 3'h0;
    I_SEL_PAIR <= ~lf;
    press;
    chk(16'h0001, {15'h0000, O_RUN}, "run");
    chk(lf[15:0], O_SECOND_DISP, "static");
    I_MODE_SEL <= 3'h1;
    press;
    chk(16'h0000, {15'h0000, O_RUN}, "halt");
    give_verdict;
  end
endmodule // tb_console_display_panel_port
